// >>> pkg/ssx_consts.svh
`ifndef SSX_CONSTS_SVH
`define SSX_CONSTS_SVH

// ****************************************************************
// opcode match masks
// ****************************************************************
`define SSX_M_FULL       8'hff
`define SSX_M_REG        8'hf8
`define SSX_M_PTR        8'hfe

// ****************************************************************
// opcode patterns
// ****************************************************************
`define SSX_OPC_SUBW_REG 8'h98
`define SSX_OPC_SUBW_DIR 8'h95
`define SSX_OPC_SUBW_IND 8'h96
`define SSX_OPC_SUBW_IMM 8'h94
`define SSX_OPC_NSWAP    8'hc4
`define SSX_OPC_BXCG_REG 8'hc8
`define SSX_OPC_BXCG_DIR 8'hc5
`define SSX_OPC_BXCG_IND 8'hc6
`define SSX_OPC_DXCG_IND 8'hd6
`define SSX_OPC_XOR_REG  8'h68
`define SSX_OPC_XOR_DIR  8'h65
`define SSX_OPC_XOR_IND  8'h66
`define SSX_OPC_XOR_IMM  8'h64
`define SSX_OPC_XORM_ACC 8'h62
`define SSX_OPC_XORM_IMM 8'h63

// ****************************************************************
// field positions, reset values, lengths and cycle counts
// ****************************************************************
`define SSX_RSEL_MSB     2
`define SSX_PSEL_BIT     0
`define SSX_ACC_RST      8'h00
`define SSX_FLAG_RST     1'b0
`define SSX_LEN_1        2'h1
`define SSX_LEN_2        2'h2
`define SSX_LEN_3        2'h3
`define SSX_CYC_1        2'h1
`define SSX_CYC_2        2'h2

`endif

// >>> pkg/ssx_pkg.sv
`default_nettype none

package ssx_pkg;

  // ****************************************************************
  // enumerations
  // ****************************************************************
  typedef enum logic [1:0] {SP_NONE, SP_REG, SP_DIR, SP_IND} ssx_space_e;
  typedef enum logic [1:0] {SRC_MEM, SRC_ARG1, SRC_ARG2, SRC_ACC} ssx_src_e;
  typedef enum logic [2:0] {
    OP_NONE, OP_SUB_BORROW, OP_NIB_SWAP, OP_BYTE_XCG,
    OP_DIGIT_XCG, OP_XOR_ACC, OP_XOR_MEM
  } ssx_op_e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] arg1;
    logic [7:0] arg2;
  } ssx_issue_s;

  typedef struct packed {
    logic       legal;
    ssx_op_e    op;
    ssx_space_e space;
    ssx_src_e   src;
    logic [7:0] addr;
    logic [1:0] len;
    logic [1:0] cyc;
  } ssx_dec_s;

  typedef struct packed {
    logic       valid;
    ssx_space_e space;
    logic [7:0] addr;
  } ssx_rd_s;

  typedef struct packed {
    logic       valid;
    ssx_space_e space;
    logic [7:0] addr;
    logic [7:0] data;
  } ssx_wr_s;

  typedef struct packed {
    logic [7:0] pins;
    logic [7:0] latch;
    logic       is_port;
  } ssx_rsp_s;

  typedef struct packed {
    logic       acc_en;
    logic [7:0] acc;
    logic       psw_en;
    logic       cy;
    logic       ac;
    logic       ov;
  } ssx_ld_s;

endpackage

`default_nettype wire

// >>> src/ssx_decode.sv
`include "ssx_consts.svh"
`default_nettype none

module ssx_decode
  import ssx_pkg::*;
(
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] arg1,
  output ssx_dec_s        dec
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] opc, input logic [7:0] pat,
                               input logic [7:0] msk);
    hit = ((opc & msk) == pat);
  endfunction

  function automatic ssx_dec_s mk(input ssx_op_e op, input ssx_space_e sp,
                                  input ssx_src_e src, input logic [7:0] addr,
                                  input logic [1:0] len, input logic [1:0] cyc);
    mk = '{legal: 1'b1, op: op, space: sp, src: src, addr: addr, len: len, cyc: cyc};
  endfunction

  // ****************************************************************
  // operand location from low opcode bits
  // ****************************************************************
  logic [7:0] reg_addr;
  logic [7:0] ptr_addr;
  assign reg_addr = {5'h0, opcode[`SSX_RSEL_MSB:0]};
  assign ptr_addr = {7'h0, opcode[`SSX_PSEL_BIT]};

  // ****************************************************************
  // opcode table
  // ****************************************************************
  assign dec =
    hit(opcode, `SSX_OPC_SUBW_REG, `SSX_M_REG) ?
      mk(OP_SUB_BORROW, SP_REG, SRC_MEM, reg_addr, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_SUBW_DIR, `SSX_M_FULL) ?
      mk(OP_SUB_BORROW, SP_DIR, SRC_MEM, arg1, `SSX_LEN_2, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_SUBW_IND, `SSX_M_PTR) ?
      mk(OP_SUB_BORROW, SP_IND, SRC_MEM, ptr_addr, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_SUBW_IMM, `SSX_M_FULL) ?
      mk(OP_SUB_BORROW, SP_NONE, SRC_ARG1, 8'h00, `SSX_LEN_2, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_NSWAP, `SSX_M_FULL) ?
      mk(OP_NIB_SWAP, SP_NONE, SRC_ACC, 8'h00, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_BXCG_REG, `SSX_M_REG) ?
      mk(OP_BYTE_XCG, SP_REG, SRC_MEM, reg_addr, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_BXCG_DIR, `SSX_M_FULL) ?
      mk(OP_BYTE_XCG, SP_DIR, SRC_MEM, arg1, `SSX_LEN_2, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_BXCG_IND, `SSX_M_PTR) ?
      mk(OP_BYTE_XCG, SP_IND, SRC_MEM, ptr_addr, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_DXCG_IND, `SSX_M_PTR) ?
      mk(OP_DIGIT_XCG, SP_IND, SRC_MEM, ptr_addr, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_XOR_REG, `SSX_M_REG) ?
      mk(OP_XOR_ACC, SP_REG, SRC_MEM, reg_addr, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_XOR_DIR, `SSX_M_FULL) ?
      mk(OP_XOR_ACC, SP_DIR, SRC_MEM, arg1, `SSX_LEN_2, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_XOR_IND, `SSX_M_PTR) ?
      mk(OP_XOR_ACC, SP_IND, SRC_MEM, ptr_addr, `SSX_LEN_1, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_XOR_IMM, `SSX_M_FULL) ?
      mk(OP_XOR_ACC, SP_NONE, SRC_ARG1, 8'h00, `SSX_LEN_2, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_XORM_ACC, `SSX_M_FULL) ?
      mk(OP_XOR_MEM, SP_DIR, SRC_ACC, arg1, `SSX_LEN_2, `SSX_CYC_1) :
    hit(opcode, `SSX_OPC_XORM_IMM, `SSX_M_FULL) ?
      mk(OP_XOR_MEM, SP_DIR, SRC_ARG2, arg1, `SSX_LEN_3, `SSX_CYC_2) :
    '0;

endmodule // ssx_decode

`default_nettype wire

// >>> src/ssx_alu.sv
`default_nettype none

module ssx_alu
  import ssx_pkg::*;
(
  input  wire ssx_op_e    op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] opnd,
  input  wire logic [7:0] mem,
  input  wire logic       cy,
  input  wire logic       ac,
  input  wire logic       ov,
  output logic [7:0]      acc_res,
  output logic [7:0]      mem_res,
  output logic            cy_res,
  output logic            ac_res,
  output logic            ov_res
);

  // ****************************************************************
  // subtract with borrow in, borrow out in bit 8
  // ****************************************************************
  function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b,
                                     input logic c);
    sub9 = {1'b0, a} - {1'b0, b} - {8'h00, c};
  endfunction

  logic [8:0] d_full;
  logic [8:0] d_low;
  logic [8:0] d_sev;
  assign d_full = sub9(acc, opnd, cy);
  assign d_low  = sub9({4'h0, acc[3:0]}, {4'h0, opnd[3:0]}, cy);
  assign d_sev  = sub9({1'b0, acc[6:0]}, {1'b0, opnd[6:0]}, cy);

  // ****************************************************************
  // result selection
  // ****************************************************************
  logic is_sub;
  assign is_sub  = (op == OP_SUB_BORROW);
  assign cy_res  = is_sub ? d_full[8] : cy;
  assign ac_res  = is_sub ? d_low[4] : ac;
  assign ov_res  = is_sub ? (d_sev[7] ^ d_full[8]) : ov;
  assign acc_res =
    is_sub                ? d_full[7:0] :
    (op == OP_NIB_SWAP)   ? {acc[3:0], acc[7:4]} :
    (op == OP_BYTE_XCG)   ? mem :
    (op == OP_DIGIT_XCG)  ? {acc[7:4], mem[3:0]} :
    (op == OP_XOR_ACC)    ? (acc ^ opnd) :
    acc;
  assign mem_res =
    (op == OP_BYTE_XCG)   ? acc :
    (op == OP_DIGIT_XCG)  ? {mem[7:4], acc[3:0]} :
    (op == OP_XOR_MEM)    ? (mem ^ opnd) :
    mem;

endmodule // ssx_alu

`default_nettype wire

// >>> src/ssx_exec.sv
`include "ssx_consts.svh"
`default_nettype none

// Behaviour
// - subtract source and carry from accumulator
// - carry set on borrow out of bit 7
// - aux carry set on borrow from bit 3
// - overflow is borrow6 xor borrow7
// - subtract source: register, direct, indirect, immediate
// - subtract opcodes 98-9f, 95, 96-97, 94
// - nibble swap, flags kept, opcode c4
// - byte exchange swaps accumulator and operand
// - byte exchange opcodes c8-cf, c5 and c6-c7
// - digit exchange swaps low nibbles only
// - exclusive-or into destination, flags kept
// - six exclusive-or operand combinations
// - port read-modify-write uses output latch
// - xor into accumulator opcodes 68-6f, 65, 66-67, 64
// - xor accumulator into direct, opcode 62
// - xor immediate into direct, 63, two cycles
module ssx_exec
  import ssx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       issue_valid,
  input  wire ssx_issue_s issue,
  output logic            issue_ready,
  output logic            issue_err,
  output var ssx_rd_s     rd,
  input  wire ssx_rsp_s   rsp,
  output var ssx_wr_s     wr,
  input  wire ssx_ld_s    ld,
  output logic [7:0]      acc,
  output logic            carry_flag,
  output logic            aux_carry_flag,
  output logic            overflow_flag,
  output logic            done,
  output logic [1:0]      done_len
);

  // ****************************************************************
  // state and registers
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_HOLD} ssx_state_e;

  ssx_state_e state_reg;
  ssx_state_e state_next;
  ssx_issue_s ins_reg;
  ssx_issue_s ins_next;
  ssx_dec_s   dec_reg;
  ssx_dec_s   dec_next;
  ssx_rd_s    rd_reg;
  ssx_rd_s    rd_next;
  ssx_wr_s    wr_reg;
  ssx_wr_s    wr_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic       carry_flag_reg;
  logic       carry_flag_next;
  logic       aux_carry_flag_reg;
  logic       aux_carry_flag_next;
  logic       overflow_flag_reg;
  logic       overflow_flag_next;
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic       ready_reg;
  logic       ready_next;
  logic       err_reg;
  logic       err_next;
  logic       done_reg;
  logic       done_next;
  logic [1:0] len_reg;
  logic [1:0] len_next;

  // ****************************************************************
  // decode of the offered instruction
  // ****************************************************************
  ssx_dec_s dec_in;

  ssx_decode u_decode (
    .opcode (issue.opcode),
    .arg1   (issue.arg1),
    .dec    (dec_in)
  );

  // request handshake
  logic take;
  logic take_ok;
  logic needs_read;
  assign take       = issue_valid & ready_reg;
  assign take_ok    = take & dec_in.legal;
  assign needs_read = (dec_in.space != SP_NONE);              // operand location read

  // ****************************************************************
  // operand selection
  // ****************************************************************
  logic       exec_now;
  logic       one_cyc;
  logic       rmw_dst;
  logic [7:0] mem_val;
  logic [7:0] opnd;

  assign exec_now = (state_reg == ST_EXEC);
  assign one_cyc  = (dec_reg.cyc == `SSX_CYC_1);
  // xor into a location is the read-modify-write case
  assign rmw_dst  = (dec_reg.op == OP_XOR_MEM);
  assign mem_val  = (rmw_dst && rsp.is_port) ? rsp.latch : rsp.pins;

  // source by addressing combination
  assign opnd =
    (dec_reg.src == SRC_ARG1) ? ins_reg.arg1 :
    (dec_reg.src == SRC_ARG2) ? ins_reg.arg2 :
    (dec_reg.src == SRC_ACC)  ? acc_reg :
    mem_val;

  // ****************************************************************
  // arithmetic and logic
  // ****************************************************************
  logic [7:0] alu_acc;
  logic [7:0] alu_mem;
  logic       alu_cy;
  logic       alu_ac;
  logic       alu_ov;

  ssx_alu u_alu (
    .op      (dec_reg.op),
    .acc     (acc_reg),
    .opnd    (opnd),
    .mem     (mem_val),
    .cy      (carry_flag_reg),
    .ac      (aux_carry_flag_reg),
    .ov      (overflow_flag_reg),
    .acc_res (alu_acc),
    .mem_res (alu_mem),
    .cy_res  (alu_cy),
    .ac_res  (alu_ac),
    .ov_res  (alu_ov)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // one-byte and two-byte ops execute in one cycle, 63 in two
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take_ok) begin
          state_next = needs_read ? ST_READ : ST_EXEC;
        end
      end
      ST_READ: begin
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        state_next = one_cyc ? ST_IDLE : ST_HOLD;
      end
      ST_HOLD: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // next values
  // ****************************************************************
  logic writes;
  logic finish;
  assign writes = (dec_reg.op == OP_BYTE_XCG) || (dec_reg.op == OP_DIGIT_XCG) || rmw_dst;
  assign finish = (exec_now && one_cyc) || (state_reg == ST_HOLD);

  // latch the instruction when taken
  assign ins_next = take_ok ? issue : ins_reg;
  assign dec_next = take_ok ? dec_in : dec_reg;

  // operand read request, one cycle pulse
  assign rd_next = '{valid: take_ok && needs_read,
                     space: dec_in.space,
                     addr:  dec_in.addr};

  // accumulator and flags; execution wins over a core load
  assign acc_next = exec_now  ? alu_acc :
                    ld.acc_en ? ld.acc : acc_reg;
  assign carry_flag_next     = exec_now ? alu_cy :
                               ld.psw_en ? ld.cy : carry_flag_reg;
  assign aux_carry_flag_next = exec_now ? alu_ac :
                               ld.psw_en ? ld.ac : aux_carry_flag_reg;
  assign overflow_flag_next  = exec_now ? alu_ov :
                               ld.psw_en ? ld.ov : overflow_flag_reg;

  // result parked for the second cycle of the three-byte xor
  assign hold_next = exec_now ? alu_mem : hold_reg;

  // location write, one cycle pulse
  assign wr_next = '{valid: (exec_now && one_cyc && writes) || (state_reg == ST_HOLD),
                     space: dec_reg.space,
                     addr:  dec_reg.addr,
                     data:  (state_reg == ST_HOLD) ? hold_reg : alu_mem};

  // status
  assign done_next  = finish;
  assign len_next   = finish ? dec_reg.len : 2'h0;
  assign err_next   = take && !dec_in.legal;
  assign ready_next = (state_next == ST_IDLE);

  // ****************************************************************
  // flip-flops
  // ****************************************************************
  // sequencing state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      ins_reg   <= '0;
      dec_reg   <= '0;
      hold_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      ins_reg   <= ins_next;
      dec_reg   <= dec_next;
      hold_reg  <= hold_next;
    end
  end

  // architectural state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg            <= `SSX_ACC_RST;
      carry_flag_reg     <= `SSX_FLAG_RST;
      aux_carry_flag_reg <= `SSX_FLAG_RST;
      overflow_flag_reg  <= `SSX_FLAG_RST;
    end else begin
      acc_reg            <= acc_next;
      carry_flag_reg     <= carry_flag_next;
      aux_carry_flag_reg <= aux_carry_flag_next;
      overflow_flag_reg  <= overflow_flag_next;
    end
  end

  // port-side strobes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg    <= '0;
      wr_reg    <= '0;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      done_reg  <= 1'b0;
      len_reg   <= 2'h0;
    end else begin
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
      done_reg  <= done_next;
      len_reg   <= len_next;
    end
  end

  // outputs
  assign issue_ready    = ready_reg;
  assign issue_err      = err_reg;
  assign rd             = rd_reg;
  assign wr             = wr_reg;
  assign acc            = acc_reg;
  assign carry_flag     = carry_flag_reg;
  assign aux_carry_flag = aux_carry_flag_reg;
  assign overflow_flag  = overflow_flag_reg;
  assign done           = done_reg;
  assign done_len       = len_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  // independent reference values
  logic       sub_now;
  logic [7:0] ref_diff;
  logic       ref_b7;
  logic       ref_b3;
  logic       ref_b6;
  assign sub_now  = exec_now && (dec_reg.op == OP_SUB_BORROW);
  assign ref_diff = acc_reg - opnd - {7'h00, carry_flag_reg};
  assign ref_b7   = {1'b0, acc_reg} < ({1'b0, opnd} + {8'h00, carry_flag_reg});
  assign ref_b3   = {1'b0, acc_reg[3:0]} < ({1'b0, opnd[3:0]} + {4'h0, carry_flag_reg});
  assign ref_b6   = {1'b0, acc_reg[6:0]} < ({1'b0, opnd[6:0]} + {7'h00, carry_flag_reg});

  property p_sub_result;
    @(posedge clk) disable iff (!arst_n)
      sub_now |=> (acc_reg == $past(ref_diff)) && done_reg;
  endproperty
  a_sub_result: assert property (p_sub_result)
    else $error("subtract result wrong");

  property p_sub_carry;
    @(posedge clk) disable iff (!arst_n)
      sub_now |=> carry_flag_reg == $past(ref_b7);
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract carry wrong");

  property p_sub_aux;
    @(posedge clk) disable iff (!arst_n)
      sub_now |=> aux_carry_flag_reg == $past(ref_b3);
  endproperty
  a_sub_aux: assert property (p_sub_aux)
    else $error("subtract aux carry wrong");

  property p_sub_ovf;
    @(posedge clk) disable iff (!arst_n)
      sub_now |=> overflow_flag_reg == ($past(ref_b6) ^ $past(ref_b7));
  endproperty
  a_sub_ovf: assert property (p_sub_ovf)
    else $error("subtract overflow wrong");

  property p_swap;
    @(posedge clk) disable iff (!arst_n)
      (exec_now && dec_reg.op == OP_NIB_SWAP) |=>
        (acc_reg == {$past(acc_reg[3:0]), $past(acc_reg[7:4])}) && $stable(carry_flag_reg);
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");

  property p_bxcg;
    @(posedge clk) disable iff (!arst_n)
      (exec_now && dec_reg.op == OP_BYTE_XCG) |=>
        (acc_reg == $past(rsp.pins)) && wr_reg.valid && (wr_reg.data == $past(acc_reg));
  endproperty
  a_bxcg: assert property (p_bxcg)
    else $error("byte exchange wrong");

  property p_dxcg;
    @(posedge clk) disable iff (!arst_n)
      (exec_now && dec_reg.op == OP_DIGIT_XCG) |=>
        (acc_reg[7:4] == $past(acc_reg[7:4])) && (wr_reg.data[3:0] == $past(acc_reg[3:0]));
  endproperty
  a_dxcg: assert property (p_dxcg)
    else $error("digit exchange wrong");

  property p_xor_flags;
    @(posedge clk) disable iff (!arst_n)
      (exec_now && dec_reg.op == OP_XOR_ACC) |=>
        (acc_reg == ($past(acc_reg) ^ $past(opnd))) && $stable(overflow_flag_reg);
  endproperty
  a_xor_flags: assert property (p_xor_flags)
    else $error("xor into accumulator wrong");

  property p_port_latch;
    @(posedge clk) disable iff (!arst_n)
      (exec_now && rmw_dst && one_cyc && rsp.is_port) |=>
        wr_reg.data == ($past(rsp.latch) ^ $past(acc_reg));
  endproperty
  a_port_latch: assert property (p_port_latch)
    else $error("port update not from latch");

  property p_three_byte;
    @(posedge clk) disable iff (!arst_n)
      (take && issue.opcode == `SSX_OPC_XORM_IMM) |=>
        !done_reg [*3] ##1 (done_reg && wr_reg.valid && done_len == `SSX_LEN_3);
  endproperty
  a_three_byte: assert property (p_three_byte)
    else $error("three byte xor timing wrong");

  property p_reg_sel;
    @(posedge clk) disable iff (!arst_n)
      (take && (issue.opcode & `SSX_M_REG) == `SSX_OPC_XOR_REG) |=>
        rd_reg.valid && (rd_reg.space == SP_REG) && (rd_reg.addr == {5'h0, $past(issue.opcode[2:0])});
  endproperty
  a_reg_sel: assert property (p_reg_sel)
    else $error("working register select wrong");

endmodule // ssx_exec

`default_nettype wire

// >>> testbench/ssx_exec_tb.sv
`default_nettype none
module subtract_swap_exchange_xor_exec_tb_top import ssx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bench signals
  // ****************************************
  logic       clk, arst_n, issue_valid, issue_ready, issue_err, done, err_q;
  logic       carry_flag, aux_carry_flag, overflow_flag;
  logic [7:0] acc;
  logic [1:0] done_len, len_q;
  ssx_issue_s issue;
  ssx_rd_s    rd, rd_q;
  ssx_rsp_s   rsp;
  ssx_wr_s    wr, wr_q;
  ssx_ld_s    ld;
  int         errors, num_checks, cyc, lat_q;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

  ssx_exec dut_u (.clk(clk), .arst_n(arst_n), .issue_valid(issue_valid), .issue(issue),
    .issue_ready(issue_ready), .issue_err(issue_err), .rd(rd), .rsp(rsp), .wr(wr), .ld(ld),
    .acc(acc), .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag),
    .overflow_flag(overflow_flag), .done(done), .done_len(done_len));

  // clock and cycle ceiling
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // preload accumulator and flags
  task automatic setst(input logic [7:0] a, input logic c, h, v);
    @(negedge clk);
    ld = '{1'b1, a, 1'b1, c, h, v};
    @(negedge clk);
    ld = '0;
  endtask

  // offer one instruction, hold operand, capture results
  task automatic run(input logic [7:0] o, a1, a2, pins, lat, input logic prt);
    int n;
    n = 0;
    issue = '{o, a1, a2};
    rsp = '{pins, lat, prt};
    issue_valid = 1'b1;
    while (issue_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    issue_valid = 1'b0;
    rd_q = rd;
    err_q = issue_err;
    while (done !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    wr_q = wr;
    len_q = done_len;
    lat_q = n;
  endtask

  task automatic chkf(input logic [7:0] a, input logic c, h, v);
    `CHK(acc, a)
    `CHK(carry_flag, c)
    `CHK(aux_carry_flag, h)
    `CHK(overflow_flag, v)
    `CHK(done, 1'b1)
    `CHK(issue_ready, 1'b1)
    `CHK(err_q, 1'b0)
  endtask

  task automatic chkw(input logic [7:0] a, d);
    `CHK(wr_q.valid, 1'b1)
    `CHK(wr_q.addr, a)
    `CHK(wr_q.data, d)
  endtask

  task automatic t_sub();
    setst(8'hc9, 1'b1, 1'b0, 1'b0);
    run(8'h9a, 8'h00, 8'h00, 8'h54, 8'h00, 1'b0);
    `CHK(rd_q.space, SP_REG)
    `CHK(rd_q.addr, 8'h02)
    `CHK(rd_q.valid, 1'b1)
    `CHK(len_q, 2'h1)
    `CHK(lat_q, 2)
    chkf(8'h74, 1'b0, 1'b0, 1'b1);
    setst(8'h00, 1'b0, 1'b0, 1'b0);
    run(8'h94, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0);
    `CHK(len_q, 2'h2)
    `CHK(lat_q, 1)
    chkf(8'hff, 1'b1, 1'b1, 1'b0);
    run(8'h95, 8'h30, 8'h00, 8'h10, 8'h00, 1'b0);
    `CHK(rd_q.addr, 8'h30)
    chkf(8'hee, 1'b0, 1'b0, 1'b0);
    run(8'h97, 8'h00, 8'h00, 8'h7f, 8'h00, 1'b0);
    `CHK(rd_q.space, SP_IND)
    `CHK(rd_q.addr, 8'h01)
    chkf(8'h6f, 1'b0, 1'b1, 1'b1);
    run(8'h9f, 8'h00, 8'h00, 8'h6f, 8'h00, 1'b0);
    `CHK(rd_q.addr, 8'h07)
    chkf(8'h00, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_swap_xch();
    setst(8'hc5, 1'b1, 1'b1, 1'b1);
    run(8'hc4, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    `CHK(rd_q.valid, 1'b0)
    chkf(8'h5c, 1'b1, 1'b1, 1'b1);
    run(8'hcb, 8'h00, 8'h00, 8'h75, 8'h00, 1'b0);
    chkf(8'h75, 1'b1, 1'b1, 1'b1);
    chkw(8'h03, 8'h5c);
    run(8'hc5, 8'h40, 8'h00, 8'h12, 8'h00, 1'b0);
    `CHK(len_q, 2'h2)
    chkf(8'h12, 1'b1, 1'b1, 1'b1);
    chkw(8'h40, 8'h75);
    setst(8'h36, 1'b1, 1'b0, 1'b1);
    run(8'hd6, 8'h00, 8'h00, 8'h75, 8'h00, 1'b0);
    chkf(8'h35, 1'b1, 1'b0, 1'b1);
    chkw(8'h00, 8'h76);
    run(8'hc7, 8'h00, 8'h00, 8'h3f, 8'h00, 1'b0);
    chkf(8'h3f, 1'b1, 1'b0, 1'b1);
    chkw(8'h01, 8'h35);
  endtask

  task automatic t_xor();
    setst(8'hc3, 1'b1, 1'b1, 1'b1);
    run(8'h68, 8'h00, 8'h00, 8'haa, 8'h00, 1'b0);
    chkf(8'h69, 1'b1, 1'b1, 1'b1);
    `CHK(wr_q.valid, 1'b0)
    run(8'h64, 8'h0f, 8'h00, 8'h00, 8'h00, 1'b0);
    chkf(8'h66, 1'b1, 1'b1, 1'b1);
    run(8'h65, 8'h50, 8'h00, 8'hff, 8'h00, 1'b0);
    chkf(8'h99, 1'b1, 1'b1, 1'b1);
    run(8'h67, 8'h00, 8'h00, 8'h11, 8'h00, 1'b0);
    chkf(8'h88, 1'b1, 1'b1, 1'b1);
    run(8'h62, 8'h90, 8'h00, 8'h00, 8'h34, 1'b1);
    chkw(8'h90, 8'hbc);
    `CHK(len_q, 2'h2)
    run(8'h63, 8'h90, 8'h31, 8'hff, 8'h34, 1'b1);
    chkw(8'h90, 8'h05);
    `CHK(len_q, 2'h3)
    `CHK(lat_q, 3)
    chkf(8'h88, 1'b1, 1'b1, 1'b1);
    run(8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    `CHK(err_q, 1'b1)
    `CHK(acc, 8'h88)
  endtask

  // reset, then scenarios
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    issue_valid = 1'b0;
    issue = '0;
    rsp = '0;
    ld = '0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_sub();
    t_swap_xch();
    t_xor();
    end_of_test();
  end
endmodule // subtract_swap_exchange_xor_exec_tb_top
`default_nettype wire
